// >>> rtl/ert_consts.svh
/*
  Register offsets, field positions and reset values of the eight-bit
  reload timer. Assumes the includer uses the 16-bit register port.
*/
`ifndef ERT_CONSTS_SVH
`define ERT_CONSTS_SVH

// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define ERT_OFS_CLK_SEL   16'h4240
`define ERT_OFS_RELOAD    16'h4242
`define ERT_OFS_COUNTER   16'h4244
`define ERT_OFS_CONTROL   16'h4246
`define ERT_OFS_INT_CTRL  16'h4248

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ERT_BIT_RUN       0
`define ERT_BIT_RESET     1
`define ERT_BIT_ONE_SHOT  4
`define ERT_BIT_IRQ_FLAG  0
`define ERT_BIT_IRQ_EN    8

// ---------------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------------
`define ERT_RST_SELECT    4'h0
`define ERT_RST_RELOAD    8'h00
`define ERT_RST_COUNTER   8'hFF
`define ERT_SEL_RESERVED  4'hF
`define ERT_PRE_BITS      14

`endif

// >>> rtl/ert_pkg.sv
/*
  Types shared by the reload timer and its prescaler.
  Assumes ert_consts.svh is on the include path.
*/
`include "ert_consts.svh"

package ert_pkg;
  // Prescaler ratio code, counter byte and count mode
  typedef logic [3:0] ert_sel_type;
  typedef logic [7:0] ert_byte_type;
  typedef enum logic {
    ERT_REPEAT   = 1'b0,
    ERT_ONE_SHOT = 1'b1
  } ert_mode_type;
endpackage : ert_pkg

// >>> rtl/ert_pre_if.sv
/*
  Link between the timer core and its prescaler.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps

interface ert_pre_if;
  import ert_pkg::*;
  logic        run;
  logic        clear;
  ert_sel_type select;
  logic        tick;
  modport ctrl (output run, output clear, output select, input tick);
  modport pre  (input run, input clear, input select, output tick);
endinterface : ert_pre_if

// >>> rtl/ert_prescaler.sv
/*
  Power-of-two prescaler of the peripheral clock.
  Assumes run and select come from flops and clear from a write decode, all on the same clock.
*/
`timescale 1ns/1ps
`include "ert_consts.svh"

module ert_prescaler
  import ert_pkg::*;
#(
  parameter int PRE_W = `ERT_PRE_BITS
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Core link
  ert_pre_if.pre   pre
);

  logic [PRE_W-1:0] div_count;
  logic [PRE_W-1:0] mask;

  // --------------------------------------------------------------------
  // Ratio mask: low select bits set
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PRE_W; g++) begin : g_mask
      assign mask[g] = (g < int'(pre.select));
    end
  endgenerate

  // Free count, held at zero while stopped so a start is clean
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_count <= '0;
    end else if (pre.clear || !pre.run) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // Reserved code gives no ticks at all: safer than a guessed ratio
  assign pre.tick = pre.run && (pre.select != `ERT_SEL_RESERVED) &&
                    ((div_count & mask) == mask);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_reserved_code: assert property (
    (pre.select == `ERT_SEL_RESERVED) |-> !pre.tick)
    else $error("tick on reserved ratio code");

  a_div_two_spacing: assert property (
    (pre.tick && pre.select == 4'h1 && $stable(pre.select) && pre.run
     && !pre.clear) |=> !pre.tick)
    else $error("divide by two ticked twice in a row");

endmodule : ert_prescaler

// >>> rtl/ert_timer.sv
/*
  Eight-bit down-counting reload timer with underflow interrupt.
  Assumes a synchronous register master on i_ref_clk: one-cycle
  strobes, read data taken in the cycle after the read strobe.
*/
// Chosen here: the strobed register port.
// How it works
// - Count clock is divided pclk, code F reserved
// - Eight-bit reload value, read/write, resets zero
// - Live counter readable, resets to all ones
// - Mode bit one: one-shot; zero: repeat
// - Writing one to reset bit reloads counter
// - Counts only while run bit is set
// - Enable bit gates flag onto interrupt request
// - Underflow sets flag; writing one clears it
`timescale 1ns/1ps
`include "ert_consts.svh"

module ert_timer
  import ert_pkg::*;
#(
  parameter int PRE_W = `ERT_PRE_BITS
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [15:0] o_rd_data,
  // Events
  output logic             o_irq,
  output logic             o_underflow
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  ert_pre_if     pre_bus ();

  ert_sel_type   prescale_select;
  ert_byte_type  reload_value;
  ert_byte_type  counter_value;
  ert_byte_type  next_counter;
  ert_mode_type  one_shot_mode;
  logic          run_control;
  logic          irq_enable;
  logic          irq_flag;
  logic          wr_clk_sel;
  logic          wr_reload;
  logic          wr_control;
  logic          wr_int_ctrl;
  logic          counter_reset;
  logic          flag_clear;
  logic          underflow;
  logic          tick;
  logic [15:0]   next_rd_data;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Exact match on the 16-bit offset, shared by writes and reads
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] ofs);
    return addr == ofs;
  endfunction : reg_hit

  // Write strobes per register
  assign wr_clk_sel  = i_wr_en && reg_hit(i_addr, `ERT_OFS_CLK_SEL);
  assign wr_reload   = i_wr_en && reg_hit(i_addr, `ERT_OFS_RELOAD);
  assign wr_control  = i_wr_en && reg_hit(i_addr, `ERT_OFS_CONTROL);
  assign wr_int_ctrl = i_wr_en && reg_hit(i_addr, `ERT_OFS_INT_CTRL);

  // Write-only pulses; a zero written to either bit does nothing
  assign counter_reset = wr_control && i_wr_data[`ERT_BIT_RESET];
  assign flag_clear    = wr_int_ctrl && i_wr_data[`ERT_BIT_IRQ_FLAG];

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  // Prescaler restarts with a counter reset so the first period is whole
  assign pre_bus.run    = run_control;
  assign pre_bus.clear  = counter_reset;
  assign pre_bus.select = prescale_select;
  assign tick           = pre_bus.tick;

  ert_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .pre       (pre_bus.pre)
  );

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Ratio select
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prescale_select <= `ERT_RST_SELECT;
    end else if (wr_clk_sel) begin
      prescale_select <= i_wr_data[3:0];
    end
  end

  // Reload value; a new value takes effect at the next reload only
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reload_value <= `ERT_RST_RELOAD;
    end else if (wr_reload) begin
      reload_value <= i_wr_data[7:0];
    end
  end

  // Count mode
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      one_shot_mode <= ERT_REPEAT;
    end else if (wr_control) begin
      one_shot_mode <= ert_mode_type'(i_wr_data[`ERT_BIT_ONE_SHOT]);
    end
  end

  // Run bit; software write wins over the one-shot stop
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_control <= 1'b0;
    end else if (wr_control) begin
      run_control <= i_wr_data[`ERT_BIT_RUN];
    end else if (underflow && one_shot_mode == ERT_ONE_SHOT) begin
      run_control <= 1'b0;
    end
  end

  // Interrupt enable
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_enable <= 1'b0;
    end else if (wr_int_ctrl) begin
      irq_enable <= i_wr_data[`ERT_BIT_IRQ_EN];
    end
  end

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  // Underflow is a tick seen while the count already stands at zero
  assign underflow = tick && (counter_value == 8'h00);

  // Next count; a forced reset beats any tick in the same cycle
  always_comb begin
    next_counter = counter_value;
    if (counter_reset) begin
      next_counter = reload_value;
    end else if (underflow) begin
      next_counter = reload_value;
    end else if (tick) begin
      next_counter = counter_value - 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      counter_value <= `ERT_RST_COUNTER;
    end else begin
      counter_value <= next_counter;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt
  // --------------------------------------------------------------------
  // Set beats clear so an underflow during the clear write is kept
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_flag <= 1'b0;
    end else if (underflow) begin
      irq_flag <= 1'b1;
    end else if (flag_clear) begin
      irq_flag <= 1'b0;
    end
  end

  // Level request, one cycle behind the flag and enable flops
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq       <= 1'b0;
      o_underflow <= 1'b0;
    end else begin
      o_irq       <= irq_flag && irq_enable;
      o_underflow <= underflow;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Reserved and write-only bits, and unmapped offsets, read zero
  always_comb begin
    next_rd_data = 16'h0000;
    unique case (1'b1)
      reg_hit(i_addr, `ERT_OFS_CLK_SEL): begin
        next_rd_data[3:0] = prescale_select;
      end
      reg_hit(i_addr, `ERT_OFS_RELOAD): begin
        next_rd_data[7:0] = reload_value;
      end
      reg_hit(i_addr, `ERT_OFS_COUNTER): begin
        next_rd_data[7:0] = counter_value;
      end
      reg_hit(i_addr, `ERT_OFS_CONTROL): begin
        next_rd_data[`ERT_BIT_ONE_SHOT] = one_shot_mode;
        next_rd_data[`ERT_BIT_RUN]      = run_control;
      end
      reg_hit(i_addr, `ERT_OFS_INT_CTRL): begin
        next_rd_data[`ERT_BIT_IRQ_EN]   = irq_enable;
        next_rd_data[`ERT_BIT_IRQ_FLAG] = irq_flag;
      end
      default: begin
        next_rd_data = 16'h0000;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe; reads have no effect
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_unmapped_reads_zero: assert property (
    (i_rd_en && i_addr == 16'h4250) |=> (o_rd_data == 16'h0000))
    else $error("unmapped read returned data");

  a_reserved_bits_zero: assert property (
    (i_rd_en && i_addr == `ERT_OFS_COUNTER) |=> (o_rd_data[15:8] == 8'h00))
    else $error("reserved counter bits not zero");

  a_irq_follows_gate: assert property (
    (irq_flag && irq_enable) ##1 (irq_flag && irq_enable) |-> o_irq)
    else $error("interrupt not raised for enabled flag");

  a_irq_masked: assert property (
    !irq_enable ##1 !irq_enable |-> !o_irq)
    else $error("interrupt raised while disabled");

  a_reload_stored: assert property (
    wr_reload ##1 (i_rd_en && i_addr == `ERT_OFS_RELOAD)
    |=> (o_rd_data[7:0] == $past(i_wr_data[7:0], 2)))
    else $error("reload value not read back");

  a_force_reload: assert property (
    counter_reset |=> (counter_value == $past(reload_value)))
    else $error("counter reset did not reload");

  a_hold_stopped: assert property (
    (!run_control && !counter_reset) |=> $stable(counter_value))
    else $error("counter moved while stopped");

  a_decrement: assert property (
    (tick && counter_value != 8'h00 && !counter_reset)
    |=> (counter_value == $past(counter_value) - 8'h01))
    else $error("counter did not decrement");

  a_underflow_reload: assert property (
    (underflow && !counter_reset)
    |=> (counter_value == $past(reload_value)) && irq_flag)
    else $error("underflow did not reload and flag");

  a_one_shot_stop: assert property (
    (underflow && one_shot_mode == ERT_ONE_SHOT && !wr_control)
    |=> !run_control ##1 !o_underflow)
    else $error("one-shot timer kept running");

  a_flag_w1c: assert property (
    (flag_clear && !underflow) |=> !irq_flag)
    else $error("flag not cleared by writing one");

  a_flag_sticky: assert property (
    (irq_flag && !flag_clear) |=> irq_flag)
    else $error("flag lost without a clear");

  c_underflow: cover property (underflow ##1 o_underflow);
  c_one_shot: cover property (
    underflow && one_shot_mode == ERT_ONE_SHOT);
  c_irq_raised: cover property ($rose(o_irq));
  c_set_during_clear: cover property (underflow && flag_clear);

endmodule : ert_timer

// >>> verif/tb_ert_timer.sv
/*
  Self-checking bench for the eight-bit reload timer.
  Assumes ert_pkg and ert_consts.svh are compiled and on the include path.
*/
`timescale 1ns/1ps
`include "ert_consts.svh"

module tb_ert_timer;
  import ert_pkg::*;

  // ------------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------------
  logic        i_ref_clk;
  logic        i_sys_rst;
  logic [15:0] i_addr;
  logic [15:0] i_wr_data;
  logic        i_wr_en;
  logic        i_rd_en;
  logic [15:0] o_rd_data;
  logic        o_irq;
  logic        o_underflow;
  int          num_errors;
  int          check_count;

  ert_timer #(.PRE_W(14)) i_ert_timer (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_addr      (i_addr),
    .i_wr_data   (i_wr_data),
    .i_wr_en     (i_wr_en),
    .i_rd_en     (i_rd_en),
    .o_rd_data   (o_rd_data),
    .o_irq       (o_irq),
    .o_underflow (o_underflow)
  );

  // 10 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  // Compare one value; unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; strobe drops at the edge that takes it
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge i_ref_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= addr;
    i_wr_data <= data;
    @(posedge i_ref_clk);
    i_wr_en   <= 1'b0;
  endtask : wr

  // Write strobe followed at once by a read strobe of the same offset
  task automatic wr_rd_chk(input logic [15:0] addr,
                           input logic [15:0] data,
                           input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= addr;
    i_wr_data <= data;
    @(posedge i_ref_clk);
    i_wr_en   <= 1'b0;
    i_rd_en   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en   <= 1'b0;
    #10;
    chk(o_rd_data, exp);
  endtask : wr_rd_chk

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1;
    i_addr  <= addr;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #10;
    chk(o_rd_data, exp);
  endtask : rd_chk

  // Cycles until the next underflow pulse, bounded
  task automatic wait_uf(input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_underflow !== 1'b1 && n < lim);
  endtask : wait_uf

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values;
    rd_chk(`ERT_OFS_CLK_SEL, 16'h0000);
    rd_chk(`ERT_OFS_RELOAD, 16'h0000);
    rd_chk(`ERT_OFS_COUNTER, 16'h00FF);
    rd_chk(`ERT_OFS_CONTROL, 16'h0000);
    rd_chk(`ERT_OFS_INT_CTRL, 16'h0000);
    rd_chk(16'h4250, 16'h0000);
    $display("test_reset_values done");
  endtask : test_reset_values

  // Reserved bits, read-only counter and unmapped write
  task automatic test_registers;
    wr_rd_chk(`ERT_OFS_RELOAD, 16'hFFA5, 16'h00A5);
    wr(`ERT_OFS_CLK_SEL, 16'hFFF3);
    rd_chk(`ERT_OFS_CLK_SEL, 16'h0003);
    wr(`ERT_OFS_COUNTER, 16'h0012);
    rd_chk(`ERT_OFS_COUNTER, 16'h00FF);
    wr(`ERT_OFS_INT_CTRL, 16'hFFFE);
    rd_chk(`ERT_OFS_INT_CTRL, 16'h0100);
    wr(`ERT_OFS_INT_CTRL, 16'h0000);
    wr(`ERT_OFS_CONTROL, 16'h0010);
    rd_chk(`ERT_OFS_CONTROL, 16'h0010);
    wr(16'h4250, 16'hFFFF);
    rd_chk(16'h4250, 16'h0000);
    $display("test_registers done");
  endtask : test_registers

  // One-shot run, stop, reset bit and interrupt gating
  task automatic test_one_shot_irq;
    wr(`ERT_OFS_CLK_SEL, 16'h0000);
    wr(`ERT_OFS_RELOAD, 16'h0002);
    wr(`ERT_OFS_CONTROL, 16'h0013);
    repeat (10) @(posedge i_ref_clk);
    rd_chk(`ERT_OFS_CONTROL, 16'h0010);
    rd_chk(`ERT_OFS_COUNTER, 16'h0002);
    rd_chk(`ERT_OFS_INT_CTRL, 16'h0001);
    chk({15'h0, o_irq}, 16'h0000);
    wr(`ERT_OFS_INT_CTRL, 16'h0100);
    repeat (2) @(posedge i_ref_clk);
    #10 chk({15'h0, o_irq}, 16'h0001);
    rd_chk(`ERT_OFS_INT_CTRL, 16'h0101);
    wr(`ERT_OFS_INT_CTRL, 16'h0001);
    repeat (2) @(posedge i_ref_clk);
    #10 chk({15'h0, o_irq}, 16'h0000);
    rd_chk(`ERT_OFS_INT_CTRL, 16'h0000);
    // Stopped counter holds; reset bit written 0 must not reload
    wr(`ERT_OFS_RELOAD, 16'h0077);
    wr(`ERT_OFS_CONTROL, 16'h0000);
    repeat (20) @(posedge i_ref_clk);
    rd_chk(`ERT_OFS_COUNTER, 16'h0002);
    wr(`ERT_OFS_CONTROL, 16'h0002);
    rd_chk(`ERT_OFS_COUNTER, 16'h0077);
    rd_chk(`ERT_OFS_CONTROL, 16'h0000);
    $display("test_one_shot_irq done");
  endtask : test_one_shot_irq

  // Repeat mode period is (reload+1) ticks of 2^k cycles
  task automatic test_prescale_repeat;
    int n;
    wr(`ERT_OFS_RELOAD, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      wr(`ERT_OFS_CLK_SEL, 16'(k));
      wr(`ERT_OFS_CONTROL, 16'h0003);
      wait_uf(200, n);
      chk(16'(n < 200), 16'h0001);
      wait_uf(200, n);
      chk(16'(n), 16'(2 << k));
      wr(`ERT_OFS_CONTROL, 16'h0000);
    end
    // Reserved code gives no count clock
    wr(`ERT_OFS_CLK_SEL, 16'h000F);
    wr(`ERT_OFS_CONTROL, 16'h0003);
    wait_uf(64, n);
    chk({15'h0, o_underflow}, 16'h0000);
    rd_chk(`ERT_OFS_COUNTER, 16'h0001);
    wr(`ERT_OFS_CONTROL, 16'h0000);
    $display("test_prescale_repeat done");
  endtask : test_prescale_repeat

  // ------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Whole run needs about 350 cycles; allow over forty times that
  initial begin
    repeat (15000) @(posedge i_ref_clk);
    num_errors++;
    conclude();
  end

  initial begin
    num_errors  = 0;
    check_count = 0;
    i_sys_rst   = 1'b1;
    i_addr      = 16'h0000;
    i_wr_data   = 16'h0000;
    i_wr_en     = 1'b0;
    i_rd_en     = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    test_reset_values();
    test_registers();
    test_one_shot_irq();
    test_prescale_repeat();
    conclude();
  end
endmodule : tb_ert_timer
